// *** logic/gmp_pkg.sv ***
// shared constants and types for the global memory port handshake
package gmp_pkg;
  localparam int   DATA_W     = 48;
  localparam int   ERR_W      = 4;
  localparam int   ERR_ADDR   = 0;
  localparam int   ERR_READ   = 1;
  localparam int   ERR_WRITE  = 2;
  localparam int   ERR_UNCORR = 3;
  localparam int   XPIN_W     = DATA_W + ERR_W + 2;
  localparam int   CABLE_W    = 6;
  localparam int   CIN_STOP   = 0;
  localparam int   CIN_CLEAR  = 1;
  localparam int   CIN_LOAD   = 2;
  localparam int   CIN_MSG    = 3;
  localparam int   CIN_EXT    = 4;
  localparam int   CIN_ALARM  = 5;
  localparam logic LVL_OFF    = 1'b0;
  localparam logic LVL_ON     = 1'b1;

  typedef enum logic [4:0] {
    XF_IDLE = 5'h01,
    XF_REQ  = 5'h02,
    XF_WAIT = 5'h04,
    XF_ACK  = 5'h08,
    XF_REL  = 5'h10
  } gmp_xfer_state_t;
endpackage

// *** logic/gmp_xfer_if.sv ***
// bundle between the port top and its access handshake engine
`timescale 1ns/1ps
interface gmp_xfer_if;
  logic                         start;
  logic                         write;
  logic                         protect;
  logic                         parity;
  logic                         abort;
  logic                         obtained;
  logic                         begun;
  logic [gmp_pkg::ERR_W-1:0]    err;
  logic [gmp_pkg::DATA_W-1:0]   data;
  logic                         req;
  logic                         wr_out;
  logic                         par_out;
  logic                         prot_out;
  logic                         ack;
  logic                         done;
  logic                         busy;
  logic [gmp_pkg::ERR_W-1:0]    cap_err;
  logic [gmp_pkg::DATA_W-1:0]   cap_data;

  modport ctl (output start, write, protect, parity, abort, obtained, begun, err, data,
               input req, wr_out, par_out, prot_out, ack, done, busy, cap_err, cap_data);
  modport xfer (input start, write, protect, parity, abort, obtained, begun, err, data,
                output req, wr_out, par_out, prot_out, ack, done, busy, cap_err, cap_data);
endinterface

// *** logic/gmp_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module gmp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output wire logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else if (ce) begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// *** logic/gmp_xfer.sv ***
// request and four-phase completion engine for one global access
`timescale 1ns/1ps
module gmp_xfer (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  gmp_xfer_if.xfer  x
);
  import gmp_pkg::*;

  gmp_xfer_state_t    state_ff;
  gmp_xfer_state_t    nxt_state;
  logic               req_ff;
  logic               wr_ff;
  logic               par_ff;
  logic               prot_ff;
  logic               ack_ff;
  logic               done_ff;
  logic [ERR_W-1:0]   err_ff;
  logic [DATA_W-1:0]  data_ff;
  wire                start_ok;
  wire                capture;

  // a stale access_begun from the last access must be gone before a new start
  assign start_ok = (state_ff == XF_IDLE) && x.start && !x.begun;
  assign capture  = (state_ff == XF_WAIT) && x.obtained;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      XF_IDLE: if (start_ok) nxt_state = XF_REQ;
      XF_REQ:  if (x.begun) nxt_state = XF_WAIT;
      XF_WAIT: if (x.obtained) nxt_state = XF_ACK;
      XF_ACK:  nxt_state = XF_REL;
      XF_REL:  if (!x.obtained) nxt_state = XF_IDLE;
      default: nxt_state = XF_IDLE;
    endcase
    if (x.abort) nxt_state = XF_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= XF_IDLE;
      req_ff   <= LVL_OFF;
      wr_ff    <= LVL_OFF;
      par_ff   <= LVL_OFF;
      prot_ff  <= LVL_OFF;
      ack_ff   <= LVL_OFF;
      done_ff  <= LVL_OFF;
      err_ff   <= '0;
      data_ff  <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
      req_ff   <= (nxt_state == XF_REQ);
      par_ff   <= (nxt_state == XF_REQ) && (start_ok ? x.parity : par_ff);
      prot_ff  <= (nxt_state == XF_REQ) && (start_ok ? x.protect : prot_ff);
      wr_ff    <= (nxt_state != XF_IDLE) && (start_ok ? x.write : wr_ff);
      ack_ff   <= (nxt_state == XF_REL) && (state_ff != XF_WAIT);
      done_ff  <= (state_ff == XF_REL) && !x.obtained && !x.abort;
      if (capture) begin
        data_ff <= x.data;
        err_ff  <= x.err;
      end
    end
  end

  assign x.req      = req_ff;
  assign x.wr_out   = wr_ff;
  assign x.par_out  = par_ff;
  assign x.prot_out = prot_ff;
  assign x.ack      = ack_ff;
  assign x.done     = done_ff;
  assign x.busy     = (state_ff != XF_IDLE);
  assign x.cap_err  = err_ff;
  assign x.cap_data = data_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce || x.abort);

  sequence s_obtain;
    (state_ff == XF_WAIT) && x.obtained;
  endsequence
  property p_latch_then_ack;
    s_obtain |=> (data_ff == $past(x.data)) && !ack_ff ##1 ack_ff;
  endproperty
  a_latch_then_ack: assert property (p_latch_then_ack) else $error("ack not after latch");
  property p_hold_ack;
    ack_ff && x.obtained |=> ack_ff;
  endproperty
  a_hold_ack: assert property (p_hold_ack) else $error("ack dropped early");
  property p_release_ack;
    ack_ff && !x.obtained |=> !ack_ff && done_ff;
  endproperty
  a_release_ack: assert property (p_release_ack) else $error("ack not released");
  property p_drop_req;
    req_ff && x.begun |=> !req_ff && !par_ff && !prot_ff;
  endproperty
  a_drop_req: assert property (p_drop_req) else $error("request held past begun");
endmodule

// *** logic/gmp_top.sv ***
// processor-side global memory port: access completion and status cable
`timescale 1ns/1ps
module gmp_top (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  input  wire logic                        xfer_start,
  input  wire logic                        xfer_write,
  input  wire logic                        xfer_protect,
  input  wire logic                        xfer_parity,
  input  wire logic                        data_obtained,
  input  wire logic                        access_begun,
  input  wire logic                        address_error,
  input  wire logic                        read_error,
  input  wire logic                        write_error,
  input  wire logic                        uncorrectable_error,
  input  wire logic [gmp_pkg::DATA_W-1:0]  mem_data,
  output logic                             access_request,
  output logic                             write_request,
  output logic                             addr_parity,
  output logic                             write_protect,
  output logic                             data_obtained_ack,
  output logic                             xfer_busy,
  output logic                             xfer_done,
  output logic [gmp_pkg::DATA_W-1:0]       xfer_data,
  output logic                             err_address,
  output logic                             err_read_single,
  output logic                             err_read_multi,
  output logic                             err_write_single,
  output logic                             err_write_multi,
  output logic                             err_uncorrectable,
  output logic                             err_write_aborted,
  input  wire logic                        stop_request,
  input  wire logic                        general_clear_request,
  input  wire logic                        load_request,
  input  wire logic                        message_pending,
  input  wire logic                        external_interrupt_request,
  input  wire logic                        alarm_interrupt_request,
  input  wire logic                        op_boundary,
  input  wire logic                        resume,
  input  wire logic                        control_state,
  input  wire logic                        internal_clear,
  input  wire logic                        abnormal_in,
  input  wire logic                        idle_loop,
  input  wire logic                        running_in,
  input  wire logic                        powered_up,
  output logic                             processor_stopped,
  output logic                             clear_acknowledged,
  output logic                             abnormal_state,
  output logic                             idle_indication,
  output logic                             processor_running,
  output logic                             system_present,
  output logic                             halt_pending,
  output logic                             general_clear,
  output logic                             load_start,
  output logic                             message_waiting,
  output logic                             ext_interrupt,
  output logic                             alarm_interrupt
);
  import gmp_pkg::*;
  localparam int SYNC_W = XPIN_W + CABLE_W;
  gmp_xfer_if x ();
  wire [SYNC_W-1:0]  sync_d;
  wire [SYNC_W-1:0]  sync_q;
  wire [CABLE_W-1:0] cab_s;
  wire [XPIN_W-1:0]  xpin_s;
  wire               stop_s;
  wire               clear_s;
  wire               load_s;
  wire               msg_s;
  wire               ext_s;
  wire               alarm_s;
  wire               load_rise;
  wire               clear_rise;
  wire               halt_set;
  wire               halt_clr;
  wire               uerr_c;
  wire               rerr_c;
  wire               werr_c;

  logic halted_ff;
  logic halt_pend_ff;
  logic gen_clear_ff;
  logic clear_ack_ff;
  logic load_prev_ff;
  logic clear_prev_ff;
  logic load_start_ff;
  logic msg_ff;
  logic ext_int_ff;
  logic alarm_int_ff;
  logic abnormal_ff;
  logic idle_ff;
  logic running_ff;
  logic present_ff;
  logic err_addr_ff;
  logic err_rs_ff;
  logic err_rm_ff;
  logic err_ws_ff;
  logic err_wm_ff;
  logic err_u_ff;
  logic err_wa_ff;
  logic acc_wr_ff;
  assign sync_d = {alarm_interrupt_request, external_interrupt_request,
                   message_pending, load_request, general_clear_request, stop_request,
                   uncorrectable_error, write_error, read_error, address_error,
                   access_begun, data_obtained, mem_data};

  gmp_sync #(
    .W (SYNC_W)
  ) i_gmp_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    (sync_d),
    .q    (sync_q)
  );
  assign xpin_s = sync_q[XPIN_W-1:0];
  assign cab_s  = sync_q[SYNC_W-1:XPIN_W];

  assign stop_s  = cab_s[CIN_STOP];
  assign clear_s = cab_s[CIN_CLEAR];
  assign load_s  = cab_s[CIN_LOAD];
  assign msg_s   = cab_s[CIN_MSG];
  assign alarm_s = cab_s[CIN_ALARM];
  assign ext_s   = cab_s[CIN_EXT];
  assign x.start    = xfer_start;
  assign x.write    = xfer_write;
  assign x.protect  = xfer_protect;
  assign x.parity   = xfer_parity;
  assign x.abort    = gen_clear_ff;
  assign x.data     = xpin_s[DATA_W-1:0];
  assign x.obtained = xpin_s[DATA_W];
  assign x.begun    = xpin_s[DATA_W+1];
  assign x.err      = xpin_s[XPIN_W-1:DATA_W+2];
  gmp_xfer i_gmp_xfer (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .x    (x)
  );
  assign access_request    = x.req;
  assign write_request     = x.wr_out;
  assign addr_parity       = x.par_out;
  assign write_protect     = x.prot_out;
  assign data_obtained_ack = x.ack;
  assign xfer_done         = x.done;
  assign xfer_data         = x.cap_data;

  assign uerr_c = x.cap_err[ERR_UNCORR];
  assign rerr_c = x.cap_err[ERR_READ];
  assign werr_c = x.cap_err[ERR_WRITE];

  assign halt_set   = stop_s && op_boundary && !halted_ff;
  assign halt_clr   = halted_ff && resume && !stop_s;
  assign load_rise  = load_s && !load_prev_ff;
  assign clear_rise = clear_s && !clear_prev_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      xfer_busy <= LVL_OFF;
      err_addr_ff <= LVL_OFF;
      err_rs_ff   <= LVL_OFF;
      err_rm_ff   <= LVL_OFF;
      err_ws_ff   <= LVL_OFF;
      err_wm_ff   <= LVL_OFF;
      err_u_ff    <= LVL_OFF;
      err_wa_ff   <= LVL_OFF;
      acc_wr_ff   <= LVL_OFF;
    end else if (ce) begin
      xfer_busy <= x.busy || xfer_start;
      // write flag is gone by the done cycle, so keep the last busy value
      if (x.busy) acc_wr_ff <= x.wr_out;
      // error flags hold from one completed access to the next
      if (x.done) begin
        err_addr_ff <= x.cap_err[ERR_ADDR];
        err_rs_ff   <= rerr_c && !uerr_c;
        err_rm_ff   <= rerr_c && uerr_c;
        err_ws_ff   <= werr_c && !uerr_c;
        err_wm_ff   <= werr_c && uerr_c;
        err_u_ff    <= uerr_c;
        // the memory restored the old word; the write did not land
        err_wa_ff   <= uerr_c && acc_wr_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      halted_ff     <= LVL_OFF;
      halt_pend_ff  <= LVL_OFF;
      load_prev_ff  <= LVL_OFF;
      clear_prev_ff <= LVL_OFF;
      load_start_ff <= LVL_OFF;
    end else if (ce) begin
      if (halt_set) begin
        halted_ff <= LVL_ON;
      end else if (halt_clr) begin
        halted_ff <= LVL_OFF;
      end
      halt_pend_ff  <= stop_s && !halted_ff && !halt_set;
      load_prev_ff  <= load_s;
      clear_prev_ff <= clear_s;
      load_start_ff <= load_rise && halted_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gen_clear_ff <= LVL_OFF;
      clear_ack_ff <= LVL_OFF;
      msg_ff       <= LVL_OFF;
      ext_int_ff   <= LVL_OFF;
      alarm_int_ff <= LVL_OFF;
      abnormal_ff  <= LVL_OFF;
      idle_ff      <= LVL_OFF;
      running_ff   <= LVL_OFF;
      present_ff   <= LVL_OFF;
    end else if (ce) begin
      gen_clear_ff <= clear_s;
      clear_ack_ff <= gen_clear_ff || internal_clear;
      msg_ff       <= msg_s;
      ext_int_ff   <= ext_s && !control_state;
      alarm_int_ff <= alarm_s;
      abnormal_ff  <= abnormal_in;
      idle_ff      <= idle_loop;
      running_ff   <= running_in;
      present_ff   <= powered_up;
    end
  end

  assign err_address        = err_addr_ff;
  assign err_read_single    = err_rs_ff;
  assign err_read_multi     = err_rm_ff;
  assign err_write_single   = err_ws_ff;
  assign err_write_multi    = err_wm_ff;
  assign err_uncorrectable  = err_u_ff;
  assign err_write_aborted  = err_wa_ff;
  assign processor_stopped  = halted_ff;
  assign clear_acknowledged = clear_ack_ff;
  assign abnormal_state     = abnormal_ff;
  assign idle_indication    = idle_ff;
  assign processor_running  = running_ff;
  assign system_present     = present_ff;
  assign halt_pending       = halt_pend_ff;
  assign general_clear      = gen_clear_ff;
  assign load_start         = load_start_ff;
  assign message_waiting    = msg_ff;
  assign ext_interrupt      = ext_int_ff;
  assign alarm_interrupt    = alarm_int_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  property p_halt_at_boundary;
    $rose(halted_ff) |-> $past(stop_s) && $past(op_boundary);
  endproperty
  a_halt_at_boundary: assert property (p_halt_at_boundary) else $error("halt mid operator");
  property p_stopped_shows_halt;
    stop_s && op_boundary && !halted_ff |=> processor_stopped ##1 processor_stopped;
  endproperty
  a_stopped_shows_halt: assert property (p_stopped_shows_halt) else $error("stopped not shown");

  sequence s_clear_req;
    clear_rise;
  endsequence
  sequence s_clear_echo;
    general_clear ##1 clear_acknowledged;
  endsequence
  property p_clear_echo;
    s_clear_req |=> s_clear_echo;
  endproperty
  a_clear_echo: assert property (p_clear_echo) else $error("clear not performed or echoed");
  property p_clear_ack_cause;
    $rose(clear_acknowledged) |-> $past(general_clear) || $past(internal_clear);
  endproperty
  a_clear_ack_cause: assert property (p_clear_ack_cause) else $error("stray clear echo");
  property p_load_halted;
    load_start |-> $past(halted_ff) && $past(load_rise);
  endproperty
  a_load_halted: assert property (p_load_halted) else $error("load while running");
  property p_ext_normal;
    ext_interrupt |-> !$past(control_state) && $past(ext_s);
  endproperty
  a_ext_normal: assert property (p_ext_normal) else $error("external int in control state");
  property p_alarm_any;
    alarm_s ##1 alarm_s |-> alarm_interrupt;
  endproperty
  a_alarm_any: assert property (p_alarm_any) else $error("alarm not posted");
  property p_multi_read;
    x.done && rerr_c && uerr_c |=> err_read_multi && !err_read_single;
  endproperty
  a_multi_read: assert property (p_multi_read) else $error("multi-bit read not flagged");
  property p_abnormal;
    abnormal_in ##1 abnormal_in |-> abnormal_state;
  endproperty
  a_abnormal: assert property (p_abnormal) else $error("abnormal state not shown");
endmodule

// *** tb/gmp_mem_model.sv ***
// behavioural global memory module facing the port
`timescale 1ns/1ps
module gmp_mem_model (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       access_request,
  input  wire logic                       data_obtained_ack,
  input  wire logic                       slow,
  input  wire logic [3:0]                 err_set,
  input  wire logic [gmp_pkg::DATA_W-1:0] word,
  output logic                            access_begun,
  output logic                            data_obtained,
  output logic                            address_error,
  output logic                            read_error,
  output logic                            write_error,
  output logic                            uncorrectable_error,
  output logic [gmp_pkg::DATA_W-1:0]      mem_data
);
  import gmp_pkg::*;
  logic [3:0] errs_ff;
  logic [3:0] wait_ff;
  assign {uncorrectable_error, write_error, read_error, address_error} = errs_ff;
  always_ff @(posedge clk) begin
    // released data bus keeps changing so a late capture shows up
    if (!data_obtained) mem_data <= ~mem_data;
    if (!rstn) begin
      access_begun <= 1'b0;
      data_obtained <= 1'b0;
      errs_ff <= 4'h0;
      wait_ff <= 4'h0;
      mem_data <= '0;
    end else if (access_request && !access_begun) begin
      access_begun <= 1'b1;
      wait_ff <= slow ? 4'h9 : 4'h1;
    end else if (wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
      if (wait_ff == 4'h1) begin
        data_obtained <= 1'b1;
        errs_ff <= err_set;
        mem_data <= word;
      end
    end else if (data_obtained && data_obtained_ack) begin
      data_obtained <= 1'b0;
    end else if (access_begun && !data_obtained && !data_obtained_ack) begin
      access_begun <= 1'b0;
      errs_ff <= 4'h0;
    end
  end
endmodule

// *** tb/global_memory_port_handshake_test.sv ***
// self-checking bench for the global memory port
`timescale 1ns/1ps
module global_memory_port_handshake_test;
  import gmp_pkg::*;
  logic clk, rstn, ce, xfer_start, xfer_write, xfer_protect, xfer_parity, slow;
  logic data_obtained, access_begun, address_error, read_error, write_error;
  logic uncorrectable_error, access_request, write_request, addr_parity, write_protect;
  logic data_obtained_ack, xfer_busy, xfer_done, err_address, err_read_single;
  logic err_read_multi, err_write_single, err_write_multi, err_uncorrectable;
  logic err_write_aborted, stop_request, general_clear_request, load_request;
  logic message_pending, external_interrupt_request, alarm_interrupt_request;
  logic op_boundary, resume, control_state, internal_clear, abnormal_in, idle_loop;
  logic running_in, powered_up, processor_stopped, clear_acknowledged, abnormal_state;
  logic idle_indication, processor_running, system_present, halt_pending, general_clear;
  logic load_start, message_waiting, ext_interrupt, alarm_interrupt;
  logic [DATA_W-1:0] mem_data, xfer_data, word;
  logic [3:0] err_set;
  int failures, checked, cycles, loads;

  gmp_top i_gmp_top (.*);
  gmp_mem_model i_gmp_mem_model (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (load_start === 1'b1) loads++;
    // limit well above the few hundred cycles the run needs
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  task check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(s, v);
  endtask

  task t_acc(input logic wr, input logic sl, input logic [3:0] e);
    word = {12{e ^ {wr, sl, 2'h2}}};
    err_set = e;
    slow = sl;
    xfer_write = wr;
    xfer_protect = 1'b1;
    xfer_parity = 1'b1;
    xfer_start = 1'b1;
    cyc(1);
    xfer_start = 1'b0;
    check(xfer_busy, 1'b1);
    check(write_request, wr);
    check(write_protect, 1'b1);
    wt(access_request, 1'b0);
    check(addr_parity, 1'b0);
    check(write_protect, 1'b0);
    check(data_obtained_ack, 1'b0);
    wt(data_obtained_ack, 1'b1);
    check(xfer_data, word);
    wt(data_obtained_ack, 1'b0);
    check(data_obtained, 1'b0);
    wt(xfer_done, 1'b1);
    cyc(1);
    check({err_address, err_read_single, err_read_multi, err_write_single, err_write_multi,
           err_uncorrectable, err_write_aborted}, {e[0], e[1] & !e[3], e[1] & e[3],
           e[2] & !e[3], e[2] & e[3], e[3], e[3] & wr});
    wt(access_begun, 1'b0);
    cyc(3);
  endtask

  task t_halt;
    stop_request = 1'b1;
    load_request = 1'b1;
    cyc(6);
    check(halt_pending, 1'b1);
    check(processor_stopped, 1'b0);
    check(loads, 0);
    load_request = 1'b0;
    op_boundary = 1'b1;
    cyc(1);
    op_boundary = 1'b0;
    cyc(2);
    check(processor_stopped, 1'b1);
    check(halt_pending, 1'b0);
    load_request = 1'b1;
    cyc(6);
    check(loads, 1);
    stop_request = 1'b0;
    load_request = 1'b0;
    cyc(4);
    resume = 1'b1;
    cyc(1);
    resume = 1'b0;
    cyc(2);
    check(processor_stopped, 1'b0);
  endtask

  task t_cable;
    for (int i = 0; i < 2; i++) begin
      {general_clear_request, message_pending, abnormal_in, idle_loop, running_in,
       powered_up, external_interrupt_request, alarm_interrupt_request} = {8{i[0]}};
      cyc(4);
      check(general_clear, i[0]);
      check(clear_acknowledged, i[0]);
      check(message_waiting, i[0]);
      check(abnormal_state, i[0]);
      check(idle_indication, i[0]);
      check(processor_running, i[0]);
      check(ext_interrupt, i[0]);
      check(alarm_interrupt, i[0]);
      check(system_present, i[0]);
    end
    general_clear_request = 1'b0;
    internal_clear = 1'b1;
    control_state = 1'b1;
    cyc(4);
    check(clear_acknowledged, 1'b1);
    check(ext_interrupt, 1'b0);
    check(alarm_interrupt, 1'b1);
    {internal_clear, control_state, external_interrupt_request} = 3'h0;
    alarm_interrupt_request = 1'b0;
    cyc(4);
  endtask

  task t_abort;
    slow = 1'b1;
    xfer_write = 1'b0;
    xfer_start = 1'b1;
    cyc(1);
    xfer_start = 1'b0;
    wt(access_request, 1'b0);
    general_clear_request = 1'b1;
    cyc(6);
    check(xfer_busy, 1'b0);
    check({access_request, data_obtained_ack}, 2'h0);
    general_clear_request = 1'b0;
    cyc(8);
    check(data_obtained, 1'b1);
    check({data_obtained_ack, xfer_done}, 2'h0);
    xfer_start = 1'b1;
    cyc(1);
    xfer_start = 1'b0;
    cyc(1);
    check(access_request, 1'b0);
  endtask

  task end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    {rstn, xfer_start, xfer_write, xfer_protect, xfer_parity, slow, stop_request} = '0;
    {general_clear_request, load_request, message_pending, external_interrupt_request} = '0;
    {alarm_interrupt_request, op_boundary, resume, control_state, internal_clear} = '0;
    {abnormal_in, idle_loop, running_in, powered_up} = '0;
    ce = 1'b1;
    word = '0;
    err_set = 4'h0;
    cyc(16);
    rstn = 1'b1;
    cyc(2);
    t_acc(1'b0, 1'b0, 4'h0);
    t_acc(1'b0, 1'b1, 4'h2);
    t_acc(1'b0, 1'b0, 4'ha);
    t_acc(1'b1, 1'b0, 4'h4);
    t_acc(1'b1, 1'b1, 4'hc);
    t_acc(1'b1, 1'b0, 4'h9);
    t_halt();
    t_cable();
    t_abort();
    end_sim();
  end
endmodule
